// File: core/pcc_pkg.sv
// Shared constants for the configuration control status export.
// Assumes one user clock; both ends import this package whole.
package pcc_pkg;

  //////////////////////////////////////////////////////////////////////
  // Configuration space layout (dword indices)
  localparam logic [9:0] PCC_CMD_DW = 10'h001;
  localparam logic [9:0] PCC_CAP_DW = 10'h01c;
  localparam logic [9:0] PCC_DCTL_OFS = 10'h002;

  // Field positions
  localparam int PCC_MPS_LSB = 5;
  localparam int PCC_MRRS_LSB = 12;
  localparam int PCC_IO_BIT = 0;
  localparam int PCC_MEM_BIT = 1;
  localparam int PCC_BME_BIT = 2;
  localparam int PCC_INTX_BIT = 10;

  // Reset values and writable masks
  localparam logic [15:0] PCC_CMD_RST = 16'h0000;
  localparam logic [15:0] PCC_CMD_WMASK = 16'h0547;
  localparam logic [15:0] PCC_DCTL_RST = 16'h2810;
  localparam logic [15:0] PCC_DCTL_WMASK = 16'h7fff;

  // Size codes
  localparam logic [2:0] PCC_SIZE_MAX = 3'h5;
  localparam logic [12:0] PCC_SIZE_BASE = 13'h0080;

  //////////////////////////////////////////////////////////////////////
  // Application register map (byte offsets)
  localparam logic [11:0] PCC_A_LIMITS = 12'h000;
  localparam logic [11:0] PCC_A_BYTES = 12'h004;
  localparam logic [11:0] PCC_A_REQ = 12'h008;
  localparam logic [11:0] PCC_A_RESULT = 12'h00c;

  // Request kinds
  typedef enum logic [1:0]
  {
    PCC_K_MWR = 2'b00,
    PCC_K_MRD = 2'b01,
    PCC_K_CPL = 2'b10,
    PCC_K_RX = 2'b11
  } pcc_kind_t;

  // Size code to byte limit
  function automatic logic [12:0] pcc_bytes(input logic [2:0] code);
    pcc_bytes = PCC_SIZE_BASE << code;
  endfunction : pcc_bytes

endpackage : pcc_pkg

// File: core/pcc_status_if.sv
// Status carrier between the endpoint end and the application end.
// Assumes both ends run on the same user clock.
`timescale 1ns/1ps
interface pcc_status_if;
  logic [2:0] max_payload;
  logic [2:0] max_read_req;
  logic [7:0] func_status;

  modport dev
  (
    output max_payload,
    output max_read_req,
    output func_status
  );

  modport app
  (
    input max_payload,
    input max_read_req,
    input func_status
  );
endinterface : pcc_status_if

// File: core/pcc_dev.sv
// Endpoint end: holds Command and Device Control per function and
// exports the control settings as registered sideband status.
// Assumes configuration software accesses arrive on the plain port,
// one request per cycle, in the user clock domain.
//
// Functional notes
// - Payload size out mirrors Device Control 7:5
// - Payload code 000b 128 bytes, 101b 4096
// - Application accepts TLPs up to payload size; receives here are also capped at RX_BUF_BYTES
// - Application never sends payload above limit
// - Read request size mirrors Device Control 14:12
// - Read code 000b 128 bytes, 101b 4096
// - Application never requests reads above limit
// - Eight bit function status from Command
// - Bits 3:0 function 0 enables
// - Bits 7:4 function 1 enables
// - Application gates sent traffic on function enables; receive checks ignore them
//
// Design decisions made here: the plain configuration port to the registers and the placing of the registers.
`timescale 1ns/1ps
module pcc_dev
  import pcc_pkg::*;
#(
  parameter int NUM_FUNC = 2,
  parameter int SIZE_FUNC = 0
)
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // Configuration access port
  input wire logic i_cfg_req,
  input wire logic i_cfg_wr,
  input wire logic i_cfg_func,
  input wire logic [9:0] i_cfg_dw,
  input wire logic [3:0] i_cfg_be,
  input wire logic [31:0] i_cfg_wdata,
  output logic o_cfg_ack,
  output logic [31:0] o_cfg_rdata,
  // Status carrier
  pcc_status_if.dev st
);

  //////////////////////////////////////////////////////////////////////
  // Storage
  logic [15:0] cmd_q [NUM_FUNC];
  logic [15:0] cmd_d [NUM_FUNC];
  logic [15:0] dctl_q [NUM_FUNC];
  logic [15:0] dctl_d [NUM_FUNC];
  logic [2:0] mps_q;
  logic [2:0] mrrs_q;
  logic [7:0] fstat_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic hit_cmd;
  logic hit_dctl;
  logic [31:0] rdata_d;

  //////////////////////////////////////////////////////////////////////
  // Helpers

  // Merge a byte-enabled write into a 16-bit register
  function automatic logic [15:0] merge16
  (
    input logic [15:0] old,
    input logic [15:0] wdat,
    input logic [1:0] be,
    input logic [15:0] wmask
  );
    logic [15:0] lane;
    lane = {{8{be[1]}}, {8{be[0]}}} & wmask;
    merge16 = (old & ~lane) | (wdat & lane);
  endfunction : merge16

  // Reserved size codes keep the old setting, so the far end never
  // sees a limit outside the defined ladder
  function automatic logic [2:0] keep_size
  (
    input logic [2:0] old,
    input logic [2:0] nxt
  );
    keep_size = (nxt > PCC_SIZE_MAX) ? old : nxt;
  endfunction : keep_size

  // Four enables of one function in status order
  function automatic logic [3:0] enables(input logic [15:0] cmd);
    enables = {cmd[PCC_INTX_BIT], cmd[PCC_BME_BIT],
               cmd[PCC_MEM_BIT], cmd[PCC_IO_BIT]};
  endfunction : enables

  //////////////////////////////////////////////////////////////////////
  // Decode
  always_comb
  begin
    hit_cmd = i_cfg_req && (i_cfg_dw == PCC_CMD_DW);
    hit_dctl = i_cfg_req && (i_cfg_dw == (PCC_CAP_DW + PCC_DCTL_OFS));
  end

  //////////////////////////////////////////////////////////////////////
  // Next register values
  always_comb
  begin
    for (int f = 0; f < NUM_FUNC; f++)
    begin
      cmd_d[f] = cmd_q[f];
      dctl_d[f] = dctl_q[f];
      if (i_cfg_wr && (int'(i_cfg_func) == f))
      begin
        if (hit_cmd)
        begin
          cmd_d[f] = merge16(cmd_q[f], i_cfg_wdata[15:0],
                             i_cfg_be[1:0], PCC_CMD_WMASK);
        end
        if (hit_dctl)
        begin
          dctl_d[f] = merge16(dctl_q[f], i_cfg_wdata[15:0],
                              i_cfg_be[1:0], PCC_DCTL_WMASK);
          dctl_d[f][PCC_MPS_LSB +: 3] = keep_size(
            dctl_q[f][PCC_MPS_LSB +: 3], dctl_d[f][PCC_MPS_LSB +: 3]);
          dctl_d[f][PCC_MRRS_LSB +: 3] = keep_size(
            dctl_q[f][PCC_MRRS_LSB +: 3], dctl_d[f][PCC_MRRS_LSB +: 3]);
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Register storage
  always_ff @(posedge i_clock)
  begin
    for (int f = 0; f < NUM_FUNC; f++)
    begin
      if (!i_reset_n)
      begin
        cmd_q[f] <= PCC_CMD_RST;
        dctl_q[f] <= PCC_DCTL_RST;
      end
      else
      begin
        cmd_q[f] <= cmd_d[f];
        dctl_q[f] <= dctl_d[f];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Exported status, taken from next values so it moves on the same
  // edge as the register it mirrors
  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      mps_q <= PCC_DCTL_RST[PCC_MPS_LSB +: 3];
      mrrs_q <= PCC_DCTL_RST[PCC_MRRS_LSB +: 3];
    end
    else
    begin
      mps_q <= dctl_d[SIZE_FUNC][PCC_MPS_LSB +: 3];
      mrrs_q <= dctl_d[SIZE_FUNC][PCC_MRRS_LSB +: 3];
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      fstat_q <= {enables(PCC_CMD_RST), enables(PCC_CMD_RST)};
    end
    else
    begin
      fstat_q[3:0] <= enables(cmd_d[0]);
      fstat_q[7:4] <= enables(cmd_d[1]);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read path
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (hit_cmd)
    begin
      rdata_d[15:0] = cmd_q[i_cfg_func];
    end
    else if (hit_dctl)
    begin
      rdata_d[15:0] = dctl_q[i_cfg_func];
    end
  end

  // Every access is answered one cycle later; unmapped dwords read 0
  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= i_cfg_req;
      rdata_q <= (i_cfg_req && !i_cfg_wr) ? rdata_d : 32'h0000_0000;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_cfg_ack = ack_q;
  assign o_cfg_rdata = rdata_q;
  assign st.max_payload = mps_q;
  assign st.max_read_req = mrrs_q;
  assign st.func_status = fstat_q;

endmodule : pcc_dev

// File: core/pcc_app.sv
// Application end: checks each TLP it is asked to send or take
// against the exported limits (sends also against the enables), issues only legal ones.
// Assumes software drives it over APB on the same user clock.
`timescale 1ns/1ps
module pcc_app
  import pcc_pkg::*;
#(
  parameter int RX_BUF_BYTES = 4096
)
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // TLP issue strobe
  output logic o_tlp_go,
  output logic [1:0] o_tlp_kind,
  output logic o_tlp_func,
  output logic [12:0] o_tlp_len,
  // Status carrier
  pcc_status_if.app st
);

  //////////////////////////////////////////////////////////////////////
  // State
  logic ready_q;
  logic err_q;
  logic [31:0] rdata_q;
  logic go_q;
  logic [1:0] kind_q;
  logic func_q;
  logic [12:0] len_q;
  logic ok_q;
  logic bad_q;
  logic [7:0] n_ok_q;
  logic [7:0] n_bad_q;
  logic mapped;
  logic wr_take;
  logic [3:0] en;
  logic [12:0] pay_lim;
  logic [12:0] rd_lim;
  logic [12:0] w_len;
  logic [1:0] w_kind;
  logic allow;
  logic [31:0] rd_d;

  //////////////////////////////////////////////////////////////////////
  // Limits and check of a request written to the request register
  always_comb
  begin
    pay_lim = pcc_bytes(st.max_payload);
    rd_lim = pcc_bytes(st.max_read_req);
    w_len = i_pwdata[12:0];
    w_kind = i_pwdata[17:16];
    en = i_pwdata[20] ? st.func_status[7:4] : st.func_status[3:0];
    unique case (w_kind)
      PCC_K_MWR: allow = en[PCC_BME_BIT]
                         && (w_len <= pay_lim);
      PCC_K_MRD: allow = en[PCC_BME_BIT]
                         && (w_len <= rd_lim);
      PCC_K_CPL: allow = (en[PCC_MEM_BIT] || en[PCC_IO_BIT])
                         && (w_len <= pay_lim);
      PCC_K_RX: allow = (w_len <= pay_lim)
                        && (w_len <= 13'(RX_BUF_BYTES));
    endcase
    mapped = (i_paddr == PCC_A_LIMITS) || (i_paddr == PCC_A_BYTES)
             || (i_paddr == PCC_A_REQ) || (i_paddr == PCC_A_RESULT);
    wr_take = i_psel && i_penable && ready_q && i_pwrite
              && (i_paddr == PCC_A_REQ);
  end

  //////////////////////////////////////////////////////////////////////
  // APB: one wait-free access phase, answer registered at setup
  always_comb
  begin
    rd_d = 32'h0000_0000;
    unique case (i_paddr)
      PCC_A_LIMITS: rd_d = {16'h0000, st.func_status, 1'b0,
                            st.max_read_req, 1'b0, st.max_payload};
      PCC_A_BYTES: rd_d = {3'h0, rd_lim, 3'h0, pay_lim};
      PCC_A_RESULT: rd_d = {(13'(RX_BUF_BYTES) < pay_lim), 7'h00,
                            n_bad_q, n_ok_q, 6'h00, bad_q, ok_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      ready_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ready_q <= i_psel && !i_penable;
      err_q <= i_psel && !i_penable && !mapped;
      rdata_q <= (i_psel && !i_penable && !i_pwrite) ? rd_d : 32'h0000_0000;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Issue or refuse
  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      go_q <= 1'b0;
      kind_q <= PCC_K_MWR;
      func_q <= 1'b0;
      len_q <= 13'h0000;
      ok_q <= 1'b0;
      bad_q <= 1'b0;
      n_ok_q <= 8'h00;
      n_bad_q <= 8'h00;
    end
    else
    begin
      go_q <= wr_take && allow && (w_kind != PCC_K_RX);
      if (wr_take)
      begin
        kind_q <= w_kind;
        func_q <= i_pwdata[20];
        len_q <= w_len;
        ok_q <= allow;
        bad_q <= !allow;
        n_ok_q <= n_ok_q + {7'h00, allow};
        n_bad_q <= n_bad_q + {7'h00, !allow};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_prdata = rdata_q;
  assign o_pready = ready_q;
  assign o_pslverr = err_q;
  assign o_tlp_go = go_q;
  assign o_tlp_kind = kind_q;
  assign o_tlp_func = func_q;
  assign o_tlp_len = len_q;

endmodule : pcc_app

// File: tb/pcc_status_sva.sv
// Checker for the status carrier and the config port that feeds it.
// Assumes one user clock; the bench wires every input by name.
`timescale 1ns/1ps
module pcc_status_sva
  import pcc_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // Config port
  input wire logic i_cfg_req,
  input wire logic i_cfg_wr,
  input wire logic i_cfg_func,
  input wire logic [9:0] i_cfg_dw,
  input wire logic [3:0] i_cfg_be,
  input wire logic [31:0] i_cfg_wdata,
  input wire logic o_cfg_ack,
  // Carrier
  input wire logic [2:0] max_payload,
  input wire logic [2:0] max_read_req,
  input wire logic [7:0] func_status
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);
  //////////////////////////////////////////////////////////////////////
  // Size outputs come from function 0 only
  sequence s_dctl;
    i_cfg_req && i_cfg_wr && !i_cfg_func && i_cfg_dw == 10'h01e;
  endsequence
  sequence s_cmd;
    i_cfg_req && i_cfg_wr && i_cfg_be[1:0] == 2'h3 && i_cfg_dw == 10'h001;
  endsequence
  a_mps_follow: assert property (s_dctl ##0 i_cfg_be[0] &&
    i_cfg_wdata[7:5] <= 3'h5 |=> max_payload == $past(i_cfg_wdata[7:5]))
    else $error("payload size mismatch");
  a_mrrs_follow: assert property (s_dctl ##0 i_cfg_be[1] &&
    i_cfg_wdata[14:12] <= 3'h5 |=> max_read_req == $past(i_cfg_wdata[14:12]))
    else $error("read size mismatch");
  a_mps_reserved: assert property (s_dctl ##0 i_cfg_be[0] &&
    i_cfg_wdata[7:5] > 3'h5 |=> $stable(max_payload))
    else $error("reserved payload code taken");
  a_fn0_bits: assert property (s_cmd ##0 !i_cfg_func |=>
    func_status[3:0] == {$past(i_cfg_wdata[10]), $past(i_cfg_wdata[2:0])})
    else $error("function 0 enables wrong");
  a_fn1_bits: assert property (s_cmd ##0 i_cfg_func |=>
    func_status[7:4] == {$past(i_cfg_wdata[10]), $past(i_cfg_wdata[2:0])})
    else $error("function 1 enables wrong");
  a_hold_idle: assert property (!i_cfg_req || !i_cfg_wr ||
    (i_cfg_dw != 10'h001 && i_cfg_dw != 10'h01e) |=> $stable(max_payload)
    && $stable(max_read_req) && $stable(func_status))
    else $error("status moved without a write");
  a_reset_vals: assert property ($rose(i_reset_n) |->
    max_payload == 3'h0 && max_read_req == 3'h2 && func_status == 8'h00)
    else $error("status not at reset value");
  a_ack_pulse: assert property (o_cfg_ack == $past(i_cfg_req))
    else $error("config ack not one cycle after request");
endmodule : pcc_status_sva

// File: tb/pcie_cfg_control_status_out_tb_top.sv
// Bench: both ends joined by the carrier; config port and APB driven.
// Assumes the core files compile first; one 200 MHz clock.
`timescale 1ns/1ps
module pcie_cfg_control_status_out_tb_top;
  import pcc_pkg::*;
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_cfg_req = 1'b0;
  logic i_cfg_wr = 1'b0;
  logic i_cfg_func = 1'b0;
  logic [9:0] i_cfg_dw = 10'h000;
  logic [3:0] i_cfg_be = 4'h0;
  logic [31:0] i_cfg_wdata = 32'h0;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0;
  logic o_cfg_ack, o_pready, o_pslverr, o_tlp_go, o_tlp_func;
  logic [31:0] o_cfg_rdata, o_prdata, rd;
  logic [1:0] o_tlp_kind;
  logic [12:0] o_tlp_len;
  logic err;
  logic ack;
  int mismatches = 0;
  int check_count = 0;
  pcc_status_if st ();
  always #2.5 i_clock = ~i_clock;
  //////////////////////////////////////////////////////////////////////
  pcc_dev pcc_dev_i (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_cfg_req(i_cfg_req), .i_cfg_wr(i_cfg_wr), .i_cfg_func(i_cfg_func),
    .i_cfg_dw(i_cfg_dw), .i_cfg_be(i_cfg_be), .i_cfg_wdata(i_cfg_wdata),
    .o_cfg_ack(o_cfg_ack), .o_cfg_rdata(o_cfg_rdata), .st(st));
  pcc_app pcc_app_i (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_tlp_go(o_tlp_go),
    .o_tlp_kind(o_tlp_kind), .o_tlp_func(o_tlp_func),
    .o_tlp_len(o_tlp_len), .st(st));
  pcc_status_sva pcc_status_sva_i (.i_clock(i_clock),
    .i_reset_n(i_reset_n), .i_cfg_req(i_cfg_req), .i_cfg_wr(i_cfg_wr),
    .i_cfg_func(i_cfg_func), .i_cfg_dw(i_cfg_dw), .i_cfg_be(i_cfg_be),
    .i_cfg_wdata(i_cfg_wdata), .o_cfg_ack(o_cfg_ack),
    .max_payload(st.max_payload), .max_read_req(st.max_read_req),
    .func_status(st.func_status));
  //////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("Checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Status lands on the ack edge, so one spare edge before looking
  task automatic cfg(input logic f, input logic [9:0] a, input logic [15:0] d);
    @(posedge i_clock);
    i_cfg_req <= 1'b1;
    i_cfg_wr <= 1'b1;
    i_cfg_func <= f;
    i_cfg_dw <= a;
    i_cfg_be <= 4'h3;
    i_cfg_wdata <= {16'h0, d};
    @(posedge i_clock);
    i_cfg_req <= 1'b0;
    @(posedge i_clock);
  endtask : cfg
  // Read answer stands for one cycle; taken at the edge that ends it
  task automatic cfg_rd(input logic f, input logic [9:0] a);
    @(posedge i_clock);
    i_cfg_req <= 1'b1;
    i_cfg_wr <= 1'b0;
    i_cfg_func <= f;
    i_cfg_dw <= a;
    @(posedge i_clock);
    i_cfg_req <= 1'b0;
    @(posedge i_clock);
    rd = o_cfg_rdata;
    ack = o_cfg_ack;
  endtask : cfg_rd
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    @(posedge i_clock);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1'b1;
    for (n = 0; n < 20 && o_pready !== 1'b1; n++)
      @(posedge i_clock);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (n == 20)
    begin
      mismatches++;
      $display("Error at %0t: APB answer timed out", $time);
      stop_test();
    end
  endtask : apb
  //////////////////////////////////////////////////////////////////////
  task automatic t_rst;
    i_reset_n <= 1'b0;
    repeat (20) @(posedge i_clock);
    i_reset_n <= 1'b1;
    @(posedge i_clock);
    chk({st.max_read_req, st.max_payload, st.func_status},
      32'h1000);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h20);
  endtask : t_rst
  task automatic t_sizes;
    for (int c = 0; c < 6; c++)
    begin
      cfg(1'b0, 10'h01e, {1'b0, 3'(5 - c), 4'h0, 3'(c), 5'h00});
      chk(st.max_payload, c);
      chk(st.max_read_req, 5 - c);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, {3'h0, 13'h0080 << (5 - c), 3'h0, 13'h0080 << c});
    end
    cfg(1'b0, 10'h01e, 16'h7fe0);
    chk({st.max_read_req, st.max_payload}, 6'h05);
  endtask : t_sizes
  task automatic t_func;
    cfg(1'b0, 10'h001, 16'h0407);
    cfg(1'b1, 10'h001, 16'h0002);
    chk(st.func_status, 8'h2f);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd[15:8], 8'h2f);
    cfg(1'b0, 10'h001, 16'hffff);
    cfg_rd(1'b0, 10'h001);
    chk(ack, 1'b1);
    chk(rd, 32'h0000_0547);
    chk(st.func_status, 8'h2f);
    cfg_rd(1'b0, 10'h01e);
    chk(rd, 32'h0000_0fa0);
    cfg_rd(1'b1, 10'h000);
    chk(ack, 1'b1);
    chk(rd, 32'h0000_0000);
  endtask : t_func
  // Even entries are legal; the last one is a receive check only
  task automatic t_app;
    logic [31:0] rq [7] = '{32'h80, 32'h81, 32'h10100, 32'h10101,
      32'h120080, 32'h100040, 32'h30080};
    logic s;
    cfg(1'b0, 10'h01e, 16'h1000);
    for (int i = 0; i < 7; i++)
    begin
      s = 1'b0;
      apb(1'b1, 12'h008, rq[i]);
      repeat (3) @(posedge i_clock) s = s | o_tlp_go;
      chk(s, i % 2 == 0 && i != 6);
      chk({o_tlp_func, o_tlp_kind, o_tlp_len},
        {rq[i][20], rq[i][17:16], rq[i][12:0]});
      apb(1'b0, 12'h00c, 32'h0);
      chk(rd[1:0], i % 2 == 0 ? 2'h1 : 2'h2);
    end
    chk(rd[23:8], 16'h0304);
    apb(1'b1, 12'h010, 32'h0);
    chk(err, 1'b1);
  endtask : t_app
  initial
  begin
    t_rst();
    t_sizes();
    t_func();
    t_app();
    t_rst();
    stop_test();
  end
endmodule : pcie_cfg_control_status_out_tb_top
